//--- host_port_control_register_bench.sv
// self-checking bench driving the host end over AHB-Lite into the device end
module host_port_control_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hpc_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic ref_clk, sys_rst, hsel, hwrite, dmaXfer, coreIntr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, dmaData;
  logic hreadyout, hresp, coreRun, coreReset, dataReadyFlag, hostIntrFlag;
  logic [15:0] portAddr, ctrlWord;
  int err_total;
  int checked;
  hpc_if linkBus();
  hpc_host i_hpc_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(linkBus), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  hpc_device i_hpc_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(linkBus),
    .dmaXfer(dmaXfer), .dmaData(dmaData), .coreIntr(coreIntr), .coreRun(coreRun),
    .coreReset(coreReset), .portAddr(portAddr), .ctrlWord(ctrlWord),
    .dataReadyFlag(dataReadyFlag), .hostIntrFlag(hostIntrFlag));
  hpc_link_sva i_hpc_link_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .regSel(linkBus.regSel),
    .wrStb(linkBus.wrStb), .rdStb(linkBus.rdStb), .hostOe(linkBus.hostOe),
    .devOe(linkBus.devOe), .dataBus(linkBus.dataBus), .ctrlWord(ctrlWord), .coreRun(coreRun),
    .coreReset(coreReset), .dataReadyFlag(dataReadyFlag));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stall;
    chk(16'h0000, 16'h0001);
    end_of_test();
  endtask
  // master never assumes a latency, only the bound cuts a hang
  task automatic ready_edge;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) stall();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask
  // one port access through the command register, then poll busy
  task automatic port(input logic [3:0] s, input logic w, input logic [15:0] d,
      output logic [15:0] q);
    logic [31:0] r;
    int n;
    ahb(1'b1, HOFF_CMD, {d, 7'h00, w, 4'h0, s}, r);
    repeat (2) @(posedge ref_clk);
    n = 0;
    do begin
      ahb(1'b0, HOFF_STAT, 32'h0000_0000, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    if (r[0] !== 1'b0) stall();
    q = r[31:16];
  endtask
  task automatic pulse(input logic intr, input logic [31:0] d);
    coreIntr <= intr;
    dmaXfer <= !intr;
    dmaData <= d;
    @(posedge ref_clk);
    coreIntr <= 1'b0;
    dmaXfer <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (coreRun !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    if (coreRun !== 1'b1) stall();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] q;
    logic [31:0] r;
    wait_run();
    chk(ctrlWord, CTL_RESET);
    port(SEL_CTRL_LO, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h0001);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
    chk(r[15:0], 16'h0000);
    chk({15'h0, hresp}, 16'h0000);
  endtask
  task automatic t_restart;
    logic [15:0] q;
    port(SEL_CTRL_LO, 1'b1, 16'h0000, q);
    chk(ctrlWord, 16'h0000);
    chk({15'h0, coreRun}, 16'h0000);
    // settings written with the run bit are lost to the sequence
    port(SEL_CTRL_LO, 1'b1, 16'h001F, q);
    wait_run();
    chk(ctrlWord, CTL_RESET);
  endtask
  task automatic t_map;
    logic [15:0] q;
    port(SEL_CTRL_HI, 1'b1, 16'h0007, q);
    chk(ctrlWord, CTL_RESET);
    port(SEL_CTRL_LO, 1'b1, 16'h0003, q);
    chk(ctrlWord, 16'h0003);
    port(SEL_CTRL_HI, 1'b1, 16'h0005, q);
    chk(ctrlWord, 16'h0503);
  endtask
  task automatic t_dma;
    logic [15:0] q;
    logic [15:0] a;
    a = portAddr;
    pulse(1'b0, 32'hA1B2_C3D4);
    chk(portAddr, a);
    chk({15'h0, dataReadyFlag}, 16'h0000);
    port(SEL_CTRL_LO, 1'b1, 16'h001B, q);
    pulse(1'b0, 32'hA1B2_C3D4);
    chk(portAddr, a + 16'h0001);
    port(SEL_UDATA_LO, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h00B2);
    chk({15'h0, dataReadyFlag}, 16'h0001);
    port(SEL_UDATA_HI, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h00A1);
    chk({15'h0, dataReadyFlag}, 16'h0000);
    port(SEL_DATA_LO, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h00D4);
    port(SEL_CTRL_LO, 1'b1, 16'h000B, q);
    port(SEL_CTRL_HI, 1'b1, 16'h0000, q);
    a = portAddr;
    pulse(1'b0, 32'h7788_5A69);
    chk(portAddr, a);
    port(SEL_UDATA_LO, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h00B2);
    port(SEL_DATA_HI, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, 16'h005A);
    chk({15'h0, dataReadyFlag}, 16'h0000);
  endtask
  task automatic t_port16;
    logic [15:0] q;
    logic [15:0] a;
    logic [31:0] r;
    port(SEL_CTRL_HI, 1'b1, 16'h0002, q);
    chk(ctrlWord, 16'h020B);
    ahb(1'b1, HOFF_CFG, 32'h0000_0001, r);
    ahb(1'b0, HOFF_CFG, 32'h0000_0000, r);
    chk(r[15:0], 16'h0001);
    pulse(1'b0, 32'h0000_1234);
    port(SEL_DATA_LO, 1'b0, 16'h0000, q);
    chk(q, 16'h1234);
    chk({15'h0, dataReadyFlag}, 16'h0000);
    port(SEL_DATA_HI, 1'b0, 16'h0000, q);
    chk(q, 16'h0000);
    port(SEL_CTRL_LO, 1'b1, 16'hFFFF, q);
    chk(ctrlWord, CTL_WR_MASK);
    // wide transfer on the 16-bit port: only the upper word read empties it
    a = portAddr;
    pulse(1'b0, 32'h5566_7788);
    chk(portAddr, a + 16'h0001);
    port(SEL_CTRL_LO, 1'b0, 16'h0000, q);
    chk(q, CTL_WR_MASK | 16'h0020);
    port(SEL_DATA_LO, 1'b0, 16'h0000, q);
    chk(q, 16'h7788);
    chk({15'h0, dataReadyFlag}, 16'h0001);
    port(SEL_UDATA_LO, 1'b0, 16'h0000, q);
    chk(q, 16'h5566);
    chk({15'h0, dataReadyFlag}, 16'h0000);
    pulse(1'b1, 32'h0000_0000);
    chk({15'h0, hostIntrFlag}, 16'h0001);
    port(SEL_IRQ_LO, 1'b0, 16'h0000, q);
    chk({15'h0, hostIntrFlag}, 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    dmaXfer = 1'b0;
    dmaData = 32'h0000_0000;
    coreIntr = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_restart();
    t_map();
    t_dma();
    t_port16();
    end_of_test();
  end
endmodule

//--- hpc_device.sv
// device end: host port control register, data path flags and core run control
// ------------------------------------------------------------------
// Operation
// - core halted while run bit clear
// - run bit rising by host starts reset
// - wide bit selects 16 or 32 bit DMA
// - port width bit selects 8 or 16 lines
// - flag edge bit picks leading/trailing read
// - reset sequence clears register, sets run bit
// - host rewrites settings after each reset
// - legacy mode after reset hides high byte
// - host sets map bit before high byte
// - select 1010 writes high control byte
// - sixteen bit host writable control register; only bits 4:0 and 10:8 take host writes (CTL_WR_MASK 16'h071F)
// - host never sets wide port in legacy
// - select lines pick register, 0111 control
// ------------------------------------------------------------------
//
// Implementation choices: register access over AHB-Lite and the register offsets.
module hpc_device (
  input wire logic ref_clk,
  input wire logic sys_rst,
  hpc_if.device link,
  input wire logic dmaXfer,
  input wire logic [31:0] dmaData,
  input wire logic coreIntr,
  output logic coreRun,
  output logic coreReset,
  output logic [hpc_pkg::DATA_W-1:0] portAddr,
  output logic [hpc_pkg::DATA_W-1:0] ctrlWord,
  output logic dataReadyFlag,
  output logic hostIntrFlag
);
  import hpc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] addr_ff;
  logic [15:0] data_ff;
  logic [15:0] udata_ff;
  logic [7:0] seqCnt_ff;
  logic seqBusy_ff;
  logic coreRun_ff;
  logic coreReset_ff;
  logic drdy_ff;
  logic hint_ff;
  logic wrPrev_ff;
  logic rdPrev_ff;
  logic [3:0] rdSel_ff;
  logic [15:0] rdData_ff;
  logic devOe_ff;

  logic register_map_select;
  logic port16;
  logic wrRise;
  logic rdRise;
  logic rdFall;
  logic flagEvent;
  logic [3:0] flagSel;
  logic [3:0] dataLastSel;
  logic dmaGo;
  logic [15:0] wrBus;
  logic [15:0] nxt_ctrl;

  assign register_map_select = ctrl_ff[CTL_REGISTER_MAP_SELECT];
  assign port16 = ctrl_ff[CTL_PORT16] & register_map_select;
  assign wrRise = link.wrStb & ~wrPrev_ff;
  assign rdRise = link.rdStb & ~rdPrev_ff;
  assign rdFall = ~link.rdStb & rdPrev_ff;
  // trailing edge has lost the live select, so the one caught at the start is used
  assign flagEvent = ctrl_ff[CTL_FLGEDGE] ? rdFall : rdRise;
  assign flagSel = ctrl_ff[CTL_FLGEDGE] ? rdSel_ff : link.regSel;
  assign dmaGo = dmaXfer & ctrl_ff[CTL_DMAEN];
  // 8-bit port carries each byte on the low lines
  assign wrBus = port16 ? link.dataBus : {8'h00, link.dataBus[7:0]};
  // last byte or word of a transfer that empties the data path
  assign dataLastSel = ctrl_ff[CTL_WIDE] ? (port16 ? SEL_UDATA_LO : SEL_UDATA_HI)
                                         : (port16 ? SEL_DATA_LO : SEL_DATA_HI);

  // ----------------------------------------------------------------
  // byte or word merge for the 16-bit port registers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mergeWr(input logic [15:0] old, input logic hi,
                                          input logic full, input logic [15:0] d);
    logic [15:0] r;
    r = old;
    if (full) begin
      r = d;
    end else if (hi) begin
      r = {d[7:0], old[7:0]};
    end else begin
      r = {old[15:8], d[7:0]};
    end
    return r;
  endfunction

  // host write hits reg at even select (word or low byte) or, on the 8-bit port only, odd select (high byte)
  function automatic logic selHit(input logic [3:0] sel, input logic [3:0] lo,
                                  input logic p16);
    return (sel == lo) || (!p16 && sel == (lo | 4'h1));
  endfunction

  // ----------------------------------------------------------------
  // strobe edge history
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPrev_ff <= 1'b0;
      rdPrev_ff <= 1'b0;
      rdSel_ff <= 4'h0;
    end else begin
      wrPrev_ff <= link.wrStb;
      rdPrev_ff <= link.rdStb;
      if (rdRise) begin
        rdSel_ff <= link.regSel;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (link.regSel == SEL_CTRL_LO) begin
      nxt_ctrl = mergeWr(ctrl_ff, 1'b0, port16, wrBus) & CTL_WR_MASK;
    end else if (link.regSel == SEL_CTRL_HI && register_map_select && !port16) begin
      nxt_ctrl = mergeWr(ctrl_ff, 1'b1, 1'b0, wrBus) & CTL_WR_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_ff <= CTL_RESET;
    end else if (seqBusy_ff) begin
      if (seqCnt_ff == 8'h01) begin
        ctrl_ff <= CTL_RESET;
      end
    end else if (wrRise) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // reset sequence and core run
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seqBusy_ff <= 1'b1;
      seqCnt_ff <= 8'(RST_SEQ_CYC);
    end else if (seqBusy_ff) begin
      seqCnt_ff <= seqCnt_ff - 8'h01;
      if (seqCnt_ff == 8'h01) begin
        seqBusy_ff <= 1'b0;
      end
    end else if (wrRise && !ctrl_ff[CTL_RUN] && nxt_ctrl[CTL_RUN] &&
                 link.regSel == SEL_CTRL_LO) begin
      seqBusy_ff <= 1'b1;
      seqCnt_ff <= 8'(RST_SEQ_CYC);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      coreRun_ff <= 1'b0;
      coreReset_ff <= 1'b1;
    end else begin
      coreRun_ff <= ctrl_ff[CTL_RUN] & ~seqBusy_ff;
      coreReset_ff <= seqBusy_ff;
    end
  end

  // ----------------------------------------------------------------
  // address register, autoincrement per DMA transfer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_ff <= 16'h0000;
    end else if (!seqBusy_ff && wrRise && selHit(link.regSel, SEL_ADDR_LO, port16)) begin
      addr_ff <= mergeWr(addr_ff, link.regSel[0], port16, wrBus);
    end else if (dmaGo && ctrl_ff[CTL_AUTOINC]) begin
      addr_ff <= addr_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // data registers, filled by DMA
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_ff <= 16'h0000;
    end else if (dmaGo) begin
      data_ff <= dmaData[15:0];
    end else if (!seqBusy_ff && wrRise && selHit(link.regSel, SEL_DATA_LO, port16)) begin
      data_ff <= mergeWr(data_ff, link.regSel[0], port16, wrBus);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      udata_ff <= 16'h0000;
    end else if (dmaGo && ctrl_ff[CTL_WIDE]) begin
      udata_ff <= dmaData[31:16];
    end else if (!seqBusy_ff && wrRise && register_map_select &&
                 selHit(link.regSel, SEL_UDATA_LO, port16)) begin
      udata_ff <= mergeWr(udata_ff, link.regSel[0], port16, wrBus);
    end
  end

  // ----------------------------------------------------------------
  // data ready and interrupt flags; a set beats a clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || seqBusy_ff) begin
      drdy_ff <= 1'b0;
    end else if (dmaGo) begin
      drdy_ff <= 1'b1;
    end else if (flagEvent && flagSel == dataLastSel) begin
      drdy_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || seqBusy_ff) begin
      hint_ff <= 1'b0;
    end else if (coreIntr) begin
      hint_ff <= 1'b1;
    end else if (flagEvent && flagSel == SEL_IRQ_LO) begin
      hint_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data, registered one cycle behind the select
  // ----------------------------------------------------------------
  function automatic logic [15:0] pick(input logic [15:0] w, input logic hi, input logic p16);
    return p16 ? w : (hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
  endfunction

  logic [15:0] ctrlView;
  logic [15:0] rdMux;
  assign ctrlView = {ctrl_ff[15:7], hint_ff, drdy_ff, ctrl_ff[4:0]};

  always_comb begin
    rdMux = 16'h0000;
    if (selHit(link.regSel, SEL_ADDR_LO, port16)) begin
      rdMux = pick(addr_ff, link.regSel[0], port16);
    end else if (selHit(link.regSel, SEL_DATA_LO, port16)) begin
      rdMux = pick(data_ff, link.regSel[0], port16);
    end else if (link.regSel == SEL_CTRL_LO) begin
      rdMux = pick(ctrlView, 1'b0, port16);
    end else if (link.regSel == SEL_CTRL_HI && register_map_select && !port16) begin
      rdMux = pick(ctrlView, 1'b1, 1'b0);
    end else if (register_map_select && selHit(link.regSel, SEL_UDATA_LO, port16)) begin
      rdMux = pick(udata_ff, link.regSel[0], port16);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdData_ff <= 16'h0000;
      devOe_ff <= 1'b0;
    end else begin
      rdData_ff <= rdMux;
      devOe_ff <= link.rdStb;
    end
  end

  assign link.devDout = rdData_ff;
  assign link.devOe = devOe_ff;
  assign coreRun = coreRun_ff;
  assign coreReset = coreReset_ff;
  assign portAddr = addr_ff;
  assign ctrlWord = ctrl_ff;
  assign dataReadyFlag = drdy_ff;
  assign hostIntrFlag = hint_ff;
endmodule

//--- hpc_host.sv
// host end: AHB-Lite command registers driving the parallel host port
module hpc_host (
  input wire logic ref_clk,
  input wire logic sys_rst,
  hpc_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import hpc_pkg::*;

  typedef enum {ST_IDLE, ST_STROBE, ST_GAP} hpc_state_t;

  hpc_state_t state_ff;
  logic [3:0] sel_ff;
  logic isWr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic port16_ff;
  logic [3:0] cnt_ff;
  logic wrStb_ff;
  logic rdStb_ff;
  logic hostOe_ff;
  logic dWr_ff;
  logic [31:0] dAddr_ff;
  logic [31:0] hrdata_ff;
  logic addrPhase;
  logic cmdGo;

  // ----------------------------------------------------------------
  // bus slave, zero wait states
  // ----------------------------------------------------------------
  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign cmdGo = dWr_ff && dAddr_ff == HOFF_CMD && state_ff == ST_IDLE;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dWr_ff <= 1'b0;
      dAddr_ff <= 32'h0000_0000;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      dWr_ff <= addrPhase & hwrite;
      dAddr_ff <= haddr;
      if (addrPhase && !hwrite) begin
        case (haddr)
          HOFF_STAT: hrdata_ff <= {rdata_ff, 15'h0000, state_ff != ST_IDLE};
          HOFF_CFG: hrdata_ff <= {31'h0000_0000, port16_ff};
          default: hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software must mirror the device width bit here after it sets it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port16_ff <= 1'b0;
    end else if (dWr_ff && dAddr_ff == HOFF_CFG) begin
      port16_ff <= hwdata[CFG_PORT16];
    end
  end

  // ----------------------------------------------------------------
  // port access sequencer; busy commands are dropped
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sel_ff <= 4'h0;
      isWr_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmdGo) begin
            state_ff <= ST_STROBE;
            cnt_ff <= 4'h0;
            sel_ff <= hwdata[3:0];
            isWr_ff <= hwdata[CMD_WRITE];
            wdata_ff <= port16_ff ? hwdata[31:16] : {8'h00, hwdata[23:16]};
          end
        end
        ST_STROBE: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'(STROBE_CYC - 1)) begin
            state_ff <= ST_GAP;
          end
        end
        ST_GAP: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrStb_ff <= 1'b0;
      rdStb_ff <= 1'b0;
      hostOe_ff <= 1'b0;
    end else if (cmdGo) begin
      wrStb_ff <= hwdata[CMD_WRITE];
      rdStb_ff <= ~hwdata[CMD_WRITE];
      hostOe_ff <= hwdata[CMD_WRITE];
    end else if (state_ff == ST_STROBE && cnt_ff == 4'(STROBE_CYC - 1)) begin
      wrStb_ff <= 1'b0;
      rdStb_ff <= 1'b0;
      hostOe_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_ff <= 16'h0000;
    end else if (state_ff == ST_STROBE && !isWr_ff && cnt_ff == 4'(STROBE_CYC - 1)) begin
      rdata_ff <= link.dataBus;
    end
  end

  assign link.regSel = sel_ff;
  assign link.wrStb = wrStb_ff;
  assign link.rdStb = rdStb_ff;
  assign link.hostDout = wdata_ff;
  assign link.hostOe = hostOe_ff;
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

//--- hpc_if.sv
// parallel host port wires between host and device
interface hpc_if;
  import hpc_pkg::*;
  logic [SEL_W-1:0] regSel;
  logic wrStb;
  logic rdStb;
  logic [DATA_W-1:0] hostDout;
  logic hostOe;
  logic [DATA_W-1:0] devDout;
  logic devOe;
  logic [DATA_W-1:0] dataBus;
  // shared data lines resolved from the two enables
  assign dataBus = devOe ? devDout : (hostOe ? hostDout : '0);
  modport host (output regSel, output wrStb, output rdStb, output hostDout, output hostOe,
    input dataBus);
  modport device (input regSel, input wrStb, input rdStb, output devDout, output devOe,
    input dataBus);
endinterface

//--- hpc_link_sva.sv
// concurrent checks on the host port link and the device control outputs
module hpc_link_sva (
  input logic ref_clk,
  input logic sys_rst,
  input logic [hpc_pkg::SEL_W-1:0] regSel,
  input logic wrStb,
  input logic rdStb,
  input logic hostOe,
  input logic devOe,
  input logic [hpc_pkg::DATA_W-1:0] dataBus,
  input logic [hpc_pkg::DATA_W-1:0] ctrlWord,
  input logic coreRun,
  input logic coreReset,
  input logic dataReadyFlag
);
  import hpc_pkg::*;
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold3(sig);
    sig[*3] ##1 !sig;
  endsequence
  // writes during a running sequence are dropped, so they are excluded
  sequence s_runWrite;
    $rose(wrStb) && regSel == SEL_CTRL_LO && dataBus[CTL_RUN] && !ctrlWord[CTL_RUN] && !coreReset;
  endsequence
  sequence s_hiWrite;
    $rose(wrStb) && regSel == SEL_CTRL_HI && !coreReset;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wrLen;
    $rose(wrStb) |-> s_hold3(wrStb);
  endproperty
  property p_rdLen;
    $rose(rdStb) |-> s_hold3(rdStb);
  endproperty
  property p_selHold;
    ($rose(wrStb) || $rose(rdStb)) |=> $stable(regSel)[*3];
  endproperty
  property p_busOwner;
    wrStb |-> hostOe && !devOe;
  endproperty
  // fall cycle plus the gap cycle: no strobe may restart inside them
  property p_gap;
    ($fell(wrStb) || $fell(rdStb)) |-> (!wrStb && !rdStb)[*2];
  endproperty
  property p_runStart;
    s_runWrite |-> ##[1:3] coreReset;
  endproperty
  property p_seqEnd;
    $fell(coreReset) |-> ##[0:2] ctrlWord == CTL_RESET;
  endproperty
  property p_halt;
    !ctrlWord[CTL_RUN] |=> !coreRun;
  endproperty
  property p_run;
    (ctrlWord[CTL_RUN] && !coreReset)[*3] |-> coreRun;
  endproperty
  property p_legacyHi;
    s_hiWrite ##0 !ctrlWord[CTL_REGISTER_MAP_SELECT] |=> $stable(ctrlWord[10:8])[*3];
  endproperty
  // device takes the byte on the first strobe cycle, so it shows one cycle later
  property p_hiWrite;
    s_hiWrite ##0 (ctrlWord[CTL_REGISTER_MAP_SELECT] && !ctrlWord[CTL_PORT16])
      |=> ctrlWord[10:8] == $past(dataBus[2:0]);
  endproperty
  // leading edge: flag drops while the strobe is still high
  property p_leadClr;
    $rose(rdStb) && regSel == SEL_DATA_HI && dataReadyFlag && ctrlWord[10:8] == 3'h0
      |-> ##[1:2] !dataReadyFlag;
  endproperty
  property p_trailClr;
    $rose(rdStb) && regSel == SEL_UDATA_HI && dataReadyFlag && ctrlWord[10:8] == 3'h5
      |=> dataReadyFlag[*2] ##[1:3] !dataReadyFlag;
  endproperty
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_wrLen: assert property (p_wrLen) else $error("write strobe length wrong");
  a_rdLen: assert property (p_rdLen) else $error("read strobe length wrong");
  a_selHold: assert property (p_selHold) else $error("select moved in strobe");
  a_busOwner: assert property (p_busOwner) else $error("data lines not host driven");
  a_gap: assert property (p_gap) else $error("no gap after strobe");
  a_runStart: assert property (p_runStart) else $error("no reset sequence on run");
  a_seqEnd: assert property (p_seqEnd) else $error("control not default after reset");
  a_halt: assert property (p_halt) else $error("core runs while halted");
  a_run: assert property (p_run) else $error("core not running");
  a_legacyHi: assert property (p_legacyHi) else $error("high byte written in legacy");
  a_hiWrite: assert property (p_hiWrite) else $error("high byte not written");
  a_leadClr: assert property (p_leadClr) else $error("flag not cleared on lead");
  a_trailClr: assert property (p_trailClr) else $error("flag not cleared on trail");
endmodule

//--- hpc_pkg.sv
// constants shared by both ends of the host port control link
package hpc_pkg;
  // ----------------------------------------------------------------
  // link shape and timing
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SEL_W = 4;
  localparam int CLK_NS = 8;
  localparam int RST_SEQ_NS = 80;
  localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = 3;
  // ----------------------------------------------------------------
  // host register selects
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_ADDR_LO = 4'h0;
  localparam logic [3:0] SEL_ADDR_HI = 4'h1;
  localparam logic [3:0] SEL_DATA_LO = 4'h2;
  localparam logic [3:0] SEL_DATA_HI = 4'h3;
  localparam logic [3:0] SEL_CTRL_LO = 4'h7;
  localparam logic [3:0] SEL_IRQ_LO = 4'h8;
  localparam logic [3:0] SEL_CTRL_HI = 4'hA;
  localparam logic [3:0] SEL_UDATA_LO = 4'hC;
  localparam logic [3:0] SEL_UDATA_HI = 4'hD;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_REGISTER_MAP_SELECT = 1;
  localparam int CTL_IRQEN = 2;
  localparam int CTL_DMAEN = 3;
  localparam int CTL_AUTOINC = 4;
  localparam int CTL_DRDY = 5;
  localparam int CTL_HINT = 6;
  localparam int CTL_WIDE = 8;
  localparam int CTL_PORT16 = 9;
  localparam int CTL_FLGEDGE = 10;
  localparam logic [15:0] CTL_RESET = 16'h0001;
  localparam logic [15:0] CTL_WR_MASK = 16'h071F;
  // ----------------------------------------------------------------
  // host command registers on the bus
  // ----------------------------------------------------------------
  localparam logic [31:0] HOFF_CMD = 32'h0000_0000;
  localparam logic [31:0] HOFF_STAT = 32'h0000_0004;
  localparam logic [31:0] HOFF_CFG = 32'h0000_0008;
  localparam int CMD_WRITE = 8;
  localparam int CFG_PORT16 = 0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
